// >>> cpsm_far_model.sv
// Behavioural memory controller and clock control circuit beside the stop controller
module cpsm_far_model
#(
    parameter int STAB = 6
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [2:0] ack_delay_i,
    input wire logic memctl_stop_req_i,
    input wire logic sw_clock_stop_req_i,
    input wire logic hw_clock_stop_req_i,
    output logic memctl_stop_ack_o,
    output logic clock_restored_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stop_q;
    logic [3:0] ack_cnt;
    logic [3:0] stab_cnt;
    logic [1:0] rel_cnt;
    // Acknowledge after a chosen delay, drop on the edge after the request falls
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || !memctl_stop_req_i)
        begin
            memctl_stop_ack_o <= 1'b0;
            ack_cnt <= 4'h0;
        end
        else if (ack_cnt >= {1'b0, ack_delay_i})
            memctl_stop_ack_o <= 1'b1;
        else
            ack_cnt <= ack_cnt + 4'h1;
    end
    // Clock counted as held off while a stop request stands; restored after settling
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            stop_q <= 1'b0;
            stab_cnt <= 4'h0;
            rel_cnt <= 2'h0;
            clock_restored_o <= 1'b0;
        end
        else
        begin
            stop_q <= sw_clock_stop_req_i | hw_clock_stop_req_i;
            if (stop_q && !(sw_clock_stop_req_i | hw_clock_stop_req_i))
                stab_cnt <= 4'(STAB);
            else if (stab_cnt != 4'h0)
                stab_cnt <= stab_cnt - 4'h1;
            if (stab_cnt == 4'h1)
                rel_cnt <= 2'h3;
            else if (rel_cnt != 2'h0)
                rel_cnt <= rel_cnt - 2'h1;
            // Three cycles high, then low again before any new entry
            clock_restored_o <= (rel_cnt != 2'h0);
        end
    end
endmodule

// >>> cpsm_map.svh
// Register offsets, field positions and reset values of the stop mode controller
`ifndef CPSM_MAP_SVH
`define CPSM_MAP_SVH

// Register byte offsets
`define CPSM_SAVE_CTL_OFFSET 8'h00
`define CPSM_STATUS_OFFSET 8'h04

// Power save control fields
`define CPSM_STOP_REQ_BIT 1
`define CPSM_NMI_MASK_LSB 4
`define CPSM_NMI_MASK_MSB 6
`define CPSM_INT_MASK_BIT 7

// Status fields
`define CPSM_ST_STATE_LSB 0
`define CPSM_ST_STATE_MSB 7
`define CPSM_ST_WAKE_NMI_BIT 8
`define CPSM_ST_WAKE_ACK_BIT 9
`define CPSM_ST_WAKE_BRANCH_BIT 10
`define CPSM_ST_WAKE_PEND_BIT 11
`define CPSM_ST_RESUME_HALT_BIT 12
`define CPSM_ST_HW_STOP_N_BIT 13
`define CPSM_ST_RESTORED_BIT 14

// Reset values
`define CPSM_SAVE_CTL_RESET 8'h00
`define CPSM_NMI_MASK_RESET 3'h0

// AXI response codes
`define CPSM_RESP_OKAY 2'h0
`define CPSM_RESP_SLVERR 2'h2

`endif

// >>> cpsm_pkg.sv
// Types shared by the stop mode controller
package cpsm_pkg;

    // Controller states, one-hot
    typedef enum logic [7:0] {
        cpsm_st_run = 8'h01,
        cpsm_st_sw_req = 8'h02,
        cpsm_st_sw_stop = 8'h04,
        cpsm_st_sw_wake = 8'h08,
        cpsm_st_hw_req = 8'h10,
        cpsm_st_hw_stop = 8'h20,
        cpsm_st_hw_lock = 8'h40,
        cpsm_st_hw_wake = 8'h80
    } cpsm_state_t;

    // Register selected by a bus address
    typedef enum logic [1:0] {
        cpsm_sel_save = 2'h0,
        cpsm_sel_status = 2'h1,
        cpsm_sel_none = 2'h2
    } cpsm_sel_t;

endpackage

// >>> cpsm_stop_ctl.sv
// Software and hardware STOP mode controller with AXI4-Lite registers
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`include "cpsm_map.svh"

module cpsm_stop_ctl
    import cpsm_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PRIO_W = 3
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [2:0] nmi_req_i,
    input wire logic int_req_i,
    input wire logic [PRIO_W-1:0] int_prio_i,
    input wire logic in_int_handler_i,
    input wire logic in_nmi_handler_i,
    input wire logic [PRIO_W-1:0] ctx_prio_i,
    input wire logic [1:0] ctx_nmi_level_i,
    input wire logic intr_ack_disable_i,
    input wire logic int_enabled_i,
    input wire logic halted_i,
    input wire logic bus_lock_i,
    input wire logic hw_stop_n_i,
    input wire logic memctl_stop_ack_i,
    input wire logic clock_restored_i,
    output logic memctl_stop_req_o,
    output logic sw_clock_stop_req_o,
    output logic hw_clock_stop_req_o,
    output logic cpu_run_o,
    output logic periph_run_o,
    output logic wake_o,
    output logic wake_nmi_o,
    output logic wake_ack_o,
    output logic wake_branch_o,
    output logic wake_pending_o,
    output logic resume_halt_o
);

    // Address to register selection, shared by read and write paths
    function automatic cpsm_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
        if (addr == ADDR_W'(`CPSM_SAVE_CTL_OFFSET))
            return cpsm_sel_save;
        else if (addr == ADDR_W'(`CPSM_STATUS_OFFSET))
            return cpsm_sel_status;
        else
            return cpsm_sel_none;
    endfunction

    // Level of the highest unmasked NMI, 0 when none
    function automatic logic [1:0] nmi_level(input logic [2:0] req);
        if (req[2])
            return 2'h3;
        else if (req[1])
            return 2'h2;
        else if (req[0])
            return 2'h1;
        else
            return 2'h0;
    endfunction

    cpsm_state_t state;
    cpsm_state_t next_state;
    logic save_stop_req;
    logic [2:0] save_nmi_mask;
    logic save_int_mask;
    logic next_stop_req;
    logic hw_stop_n_s;
    logic ack_s;
    logic restored_s;
    logic aw_hold;
    logic w_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wake_go;

    // The restore, acknowledge and hardware stop pins cross through two flops before any logic reads them
    cpsm_sync #(.WIDTH(3), .RST_VAL(3'h1)) u_sync
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i({clock_restored_i, memctl_stop_ack_i, hw_stop_n_i}),
        .sync_o({restored_s, ack_s, hw_stop_n_s})
    );

    // Wake sources; the NMI pending flag is deliberately not consulted
    wire [2:0] nmi_live = nmi_req_i & ~save_nmi_mask;
    wire nmi_wake = |nmi_live;
    wire int_wake = int_req_i & ~save_int_mask;
    wire any_wake = nmi_wake | int_wake;
    wire [1:0] new_nmi_lvl = nmi_level(nmi_live);

    // Acknowledge decision by handler context
    wire int_higher = int_prio_i < ctx_prio_i;
    wire ack_in_int = nmi_wake | (int_higher & ~intr_ack_disable_i);
    wire ack_in_nmi = nmi_wake & (new_nmi_lvl > ctx_nmi_level_i);
    wire ack_plain = nmi_wake | int_enabled_i;
    wire dec_ack = in_nmi_handler_i ? ack_in_nmi : (in_int_handler_i ? ack_in_int : ack_plain);

    // Entry and exit conditions
    wire stop_entry = (state == cpsm_st_run) && save_stop_req && hw_stop_n_s;
    wire hw_low = !hw_stop_n_s;

    // Next state of the controller
    always_comb
    begin
        next_state = state;
        case (state)
            cpsm_st_run:
                if (hw_low)
                    next_state = bus_lock_i ? cpsm_st_hw_lock : cpsm_st_hw_req;
                else if (save_stop_req)
                    next_state = cpsm_st_sw_req;
            cpsm_st_sw_req:
                if (hw_low)
                    next_state = cpsm_st_hw_req;
                else if (ack_s)
                    next_state = cpsm_st_sw_stop;
            cpsm_st_sw_stop:
                if (hw_low)
                    next_state = cpsm_st_hw_stop;
                else if (any_wake)
                    next_state = cpsm_st_sw_wake;
            cpsm_st_sw_wake:
                if (hw_low)
                    next_state = cpsm_st_hw_req;
                else if (restored_s)
                    next_state = cpsm_st_run;
            cpsm_st_hw_req:
                if (hw_stop_n_s)
                    next_state = cpsm_st_run;
                else if (ack_s)
                    next_state = cpsm_st_hw_stop;
            cpsm_st_hw_stop:
                if (hw_stop_n_s)
                    next_state = cpsm_st_hw_wake;
            cpsm_st_hw_lock:
                if (hw_stop_n_s)
                    next_state = cpsm_st_run;
                else if (!bus_lock_i)
                    next_state = cpsm_st_hw_req;
            cpsm_st_hw_wake:
                if (restored_s)
                    next_state = cpsm_st_run;
            default:
                next_state = cpsm_st_run;
        endcase
    end

    // Output levels implied by the coming state
    wire next_in_exch = (next_state != cpsm_st_run) && (next_state != cpsm_st_hw_lock);
    wire next_sw_clk = next_state == cpsm_st_sw_stop;
    wire next_hw_clk = next_state == cpsm_st_hw_stop;
    wire next_periph = (next_state == cpsm_st_run) || (next_state == cpsm_st_hw_lock);
    assign wake_go = (state == cpsm_st_sw_stop) && (next_state == cpsm_st_sw_wake);

    // AXI write side
    wire do_write = aw_hold && w_hold && !s_axi_bvalid_o;
    wire cpsm_sel_t w_sel = reg_sel(aw_addr);
    assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_hold && !s_axi_bvalid_o;

    // Stop bit: hardware clears it once software STOP is left, no race with writes
    always_comb
    begin
        next_stop_req = save_stop_req;
        if (state != cpsm_st_run)
            next_stop_req = (next_state != cpsm_st_run) && !next_state[4] && !next_state[5];
        else if (do_write && w_sel == cpsm_sel_save && w_strb[0])
            next_stop_req = w_data[`CPSM_STOP_REQ_BIT];
    end

    // AXI read side
    wire cpsm_sel_t r_sel = reg_sel(s_axi_araddr_i);
    assign s_axi_arready_o = !s_axi_rvalid_o;
    wire [31:0] save_word = {24'h000000, save_int_mask, save_nmi_mask, 2'h0, save_stop_req, 1'h0};
    wire [31:0] status_word = {17'h00000, restored_s, hw_stop_n_s, resume_halt_o,
        wake_pending_o, wake_branch_o, wake_ack_o, wake_nmi_o, state};
    wire [31:0] r_word = (r_sel == cpsm_sel_save) ? save_word :
        ((r_sel == cpsm_sel_status) ? status_word : 32'h00000000);

    // State and request outputs; reset is the system reset for every mode
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state <= cpsm_st_run;
            memctl_stop_req_o <= 1'b0;
            sw_clock_stop_req_o <= 1'b0;
            hw_clock_stop_req_o <= 1'b0;
            cpu_run_o <= 1'b1;
            periph_run_o <= 1'b1;
        end
        else
        begin
            state <= next_state;
            memctl_stop_req_o <= next_in_exch;
            sw_clock_stop_req_o <= next_sw_clk;
            hw_clock_stop_req_o <= next_hw_clk;
            cpu_run_o <= next_state == cpsm_st_run;
            periph_run_o <= next_periph;
        end
    end

    // Power save control register
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            save_stop_req <= 1'b0;
            save_nmi_mask <= `CPSM_NMI_MASK_RESET;
            save_int_mask <= 1'b0;
        end
        else
        begin
            save_stop_req <= next_stop_req;
            if (do_write && w_sel == cpsm_sel_save && w_strb[0])
            begin
                save_nmi_mask <= w_data[`CPSM_NMI_MASK_MSB:`CPSM_NMI_MASK_LSB];
                save_int_mask <= w_data[`CPSM_INT_MASK_BIT];
            end
        end
    end

    // Wake result, captured when a wake source ends software STOP; halt resume flag captured on hardware stop entry from run
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            wake_nmi_o <= 1'b0;
            wake_ack_o <= 1'b0;
            wake_branch_o <= 1'b0;
            wake_pending_o <= 1'b0;
            resume_halt_o <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            wake_o <= (state == cpsm_st_sw_wake) && (next_state == cpsm_st_run);
            if (wake_go)
            begin
                wake_nmi_o <= nmi_wake;
                wake_ack_o <= dec_ack;
                wake_branch_o <= dec_ack;
                wake_pending_o <= !dec_ack;
            end
            if (state == cpsm_st_run && hw_low)
                resume_halt_o <= halted_i;
            else if (state[1] || state[2] || state[3])
                resume_halt_o <= 1'b0;
        end
    end

    // AXI channel holding registers and responses
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `CPSM_RESP_OKAY;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `CPSM_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (do_write)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (w_sel == cpsm_sel_none) ? `CPSM_RESP_SLVERR : `CPSM_RESP_OKAY;
            end
            else if (s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= r_word;
                s_axi_rresp_o <= (r_sel == cpsm_sel_none) ? `CPSM_RESP_SLVERR : `CPSM_RESP_OKAY;
            end
            else if (s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end

    // Checks on the stop handshakes
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    // Clock request rising while the memory request stands
    sequence s_req_then_ack;
        !sw_clock_stop_req_o ##1 sw_clock_stop_req_o && memctl_stop_req_o;
    endsequence

    property p_entry_req;
        stop_entry && !hw_low |=> memctl_stop_req_o && !sw_clock_stop_req_o;
    endproperty
    a_entry_req: assert property (p_entry_req) else $error("stop entry did not request memory");

    property p_sw_after_ack;
        s_req_then_ack |-> $past(ack_s);
    endproperty
    a_sw_after_ack: assert property (p_sw_after_ack) else $error("clock request before ack");

    property p_masked_hold;
        state == cpsm_st_sw_stop && !any_wake && hw_stop_n_s |=> sw_clock_stop_req_o;
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("masked request left stop");

    property p_wake_drop;
        state == cpsm_st_sw_stop && any_wake && hw_stop_n_s
            |=> !sw_clock_stop_req_o && memctl_stop_req_o;
    endproperty
    a_wake_drop: assert property (p_wake_drop) else $error("wake did not drop clock request");

    property p_lock_no_hw;
        state == cpsm_st_hw_lock |-> !hw_clock_stop_req_o && !cpu_run_o;
    endproperty
    a_lock_no_hw: assert property (p_lock_no_hw) else $error("clock request during bus lock");

    property p_hw_exit;
        state == cpsm_st_hw_stop && hw_stop_n_s |=> !hw_clock_stop_req_o ##0 memctl_stop_req_o;
    endproperty
    a_hw_exit: assert property (p_hw_exit) else $error("hardware stop not left on rise");

    property p_hw_entry;
        $rose(hw_clock_stop_req_o) |-> $past(memctl_stop_req_o) && !cpu_run_o && !periph_run_o;
    endproperty
    a_hw_entry: assert property (p_hw_entry) else $error("hardware request out of order");

    property p_reset_quiet;
        $rose(rst_n_i) |-> !memctl_stop_req_o && !sw_clock_stop_req_o && !hw_clock_stop_req_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("requests high after reset");

    property p_restore_release;
        state == cpsm_st_sw_wake && restored_s && hw_stop_n_s
            |=> !memctl_stop_req_o && cpu_run_o ##1 !wake_o;
    endproperty
    a_restore_release: assert property (p_restore_release) else $error("memory request held");

    property p_nmi_ctx_ack;
        wake_go && in_nmi_handler_i && !nmi_wake |=> wake_pending_o && !wake_ack_o;
    endproperty
    a_nmi_ctx_ack: assert property (p_nmi_ctx_ack) else $error("maskable acked in nmi handler");

endmodule

// >>> cpsm_sync.sv
// Two-flop synchroniser for pin inputs
module cpsm_sync
    import cpsm_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            stage1 <= RST_VAL;
            sync_o <= RST_VAL;
        end
        else
        begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

// >>> test_cpu_stop_mode_control.sv
// Self-checking bench for the stop mode controller
`include "cpsm_map.svh"
module test_cpu_stop_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] STOP_W = 32'h1 << `CPSM_STOP_REQ_BIT;
    localparam logic [31:0] MASK_W = (32'h7 << `CPSM_NMI_MASK_LSB) | (32'h1 << `CPSM_INT_MASK_BIT);
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [2:0] nmi_req = 3'h0, int_prio = 3'h0, ctx_prio = 3'h0, ack_delay = 3'h0;
    logic [1:0] ctx_lvl = 2'h0;
    logic int_req = 1'b0, in_int = 1'b0, in_nmi = 1'b0, ack_dis = 1'b0, int_en = 1'b0;
    logic halted = 1'b0, bus_lock = 1'b0, hw_stop_n = 1'b1;
    logic mem_req, sw_req, hw_req, ack, restored, cpu_run, periph_run, wake;
    logic w_nmi, w_ack, w_br, w_pend, r_halt, by_nmi, e;
    logic [4:0] obs;
    int fail_count = 0;
    int tests_run = 0;
    int i, lvl, hk;
    assign obs = {hw_req, sw_req, mem_req, wake, cpu_run};
    always #2.5 clock = ~clock;
    cpsm_stop_ctl dut_u (.clock_i(clock), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .nmi_req_i(nmi_req), .int_req_i(int_req),
        .int_prio_i(int_prio), .in_int_handler_i(in_int), .in_nmi_handler_i(in_nmi),
        .ctx_prio_i(ctx_prio), .ctx_nmi_level_i(ctx_lvl), .intr_ack_disable_i(ack_dis),
        .int_enabled_i(int_en), .halted_i(halted), .bus_lock_i(bus_lock),
        .hw_stop_n_i(hw_stop_n), .memctl_stop_ack_i(ack), .clock_restored_i(restored),
        .memctl_stop_req_o(mem_req), .sw_clock_stop_req_o(sw_req),
        .hw_clock_stop_req_o(hw_req), .cpu_run_o(cpu_run), .periph_run_o(periph_run),
        .wake_o(wake), .wake_nmi_o(w_nmi), .wake_ack_o(w_ack), .wake_branch_o(w_br),
        .wake_pending_o(w_pend), .resume_halt_o(r_halt));
    cpsm_far_model far_u (.clock_i(clock), .rst_n_i(rst_n), .ack_delay_i(ack_delay),
        .memctl_stop_req_i(mem_req), .sw_clock_stop_req_i(sw_req),
        .hw_clock_stop_req_i(hw_req), .memctl_stop_ack_o(ack), .clock_restored_o(restored));

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Word and bit comparisons
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // Bounded poll, one look per cycle so single-cycle pulses are caught
    task automatic wait_bit(input int idx, input logic val);
        int n;
        n = 0;
        while (obs[idx] !== val && n < 400)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        chkb(obs[idx], val);
    endtask

    // Write with both channels offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++)
        begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (!bvalid) fail_count++;
        resp = bresp;
        bready <= 1'b0;
        #1;
    endtask
    task automatic rdw(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++)
        begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (!rvalid) fail_count++;
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        #1;
    endtask
    task automatic do_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        nmi_req <= 3'h0;
        int_req <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        #1;
    endtask

    // Software entry: memory request first, clock request only after acknowledge
    task automatic sw_enter(input logic [31:0] v);
        wr(`CPSM_SAVE_CTL_OFFSET, v);
        wait_bit(2, 1'b1);
        chk({30'h0, cpu_run, periph_run}, 32'h0);
        chkb(sw_req, 1'b0);
        wait_bit(3, 1'b1);
        chkb(ack, 1'b1);
    endtask

    function automatic logic exp_ack(input logic nmi, input int l);
        if (in_nmi)
            return nmi && l > int'(ctx_lvl);
        if (in_int)
            return nmi || (int_prio < ctx_prio && !ack_dis);
        return nmi || int_en;
    endfunction

    // Hardware stop from run, halt, software stop or under bus lock
    task automatic hw_cycle(input logic lock, input logic halt, input logic from_sw);
        if (from_sw) sw_enter(STOP_W);
        @(posedge clock);
        halted <= halt;
        bus_lock <= lock;
        hw_stop_n <= 1'b0;
        if (lock)
        begin
            repeat (12) @(posedge clock);
            #1;
            chk({29'h0, cpu_run, hw_req, mem_req}, 32'h0);
        end
        else
        begin
            wait_bit(4, 1'b1);
            chk({29'h0, mem_req, sw_req, cpu_run | periph_run}, 32'h4);
        end
        @(posedge clock);
        hw_stop_n <= 1'b1;
        wait_bit(4, 1'b0);
        wait_bit(0, 1'b1);
        chkb(r_halt, halt);
        @(posedge clock);
        bus_lock <= 1'b0;
        halted <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        fail_count++;
        test_done();
    end

    initial
    begin
        void'($urandom(22));
        do_reset();
        chk({27'h0, obs}, 32'h1);
        rdw(`CPSM_STATUS_OFFSET);
        chk(rd, 32'h1 | (32'h1 << `CPSM_ST_HW_STOP_N_BIT));
        wr(`CPSM_SAVE_CTL_OFFSET, MASK_W);
        rdw(`CPSM_SAVE_CTL_OFFSET);
        chk(rd & 32'hFF, MASK_W);
        wr(8'h08, 32'hFFFFFFFF);
        chk({30'h0, resp}, {30'h0, `CPSM_RESP_SLVERR});
        rdw(8'h08);
        chk({rd[29:0], resp}, {30'h0, `CPSM_RESP_SLVERR});
        wr(`CPSM_SAVE_CTL_OFFSET, 32'h0);
        // Random wake sources and handler contexts
        for (i = 0; i < 12; i++)
        begin
            by_nmi = 1'($urandom % 2);
            lvl = 1 + $urandom % 3;
            hk = $urandom % 3;
            @(posedge clock);
            in_int <= (hk == 1);
            in_nmi <= (hk == 2);
            int_prio <= 3'($urandom);
            ctx_prio <= 3'($urandom);
            ctx_lvl <= 2'(1 + $urandom % 3);
            ack_dis <= 1'($urandom);
            int_en <= 1'($urandom);
            ack_delay <= 3'($urandom);
            sw_enter(STOP_W);
            @(posedge clock);
            if (by_nmi) nmi_req <= 3'h1 << (lvl - 1);
            else int_req <= 1'b1;
            wait_bit(3, 1'b0);
            wait_bit(1, 1'b1);
            chkb(mem_req, 1'b0);
            e = exp_ack(by_nmi, lvl);
            chk({28'h0, w_nmi, w_ack, w_br, w_pend}, {28'h0, by_nmi, e, e, !e});
            @(posedge clock);
            nmi_req <= 3'h0;
            int_req <= 1'b0;
            repeat (6) @(posedge clock);
        end
        // All sources masked, then reset ends the stop
        sw_enter(STOP_W | MASK_W);
        @(posedge clock);
        nmi_req <= 3'h7;
        int_req <= 1'b1;
        repeat (10) @(posedge clock);
        #1;
        chk({30'h0, sw_req, cpu_run}, 32'h2);
        do_reset();
        chk({27'h0, obs}, 32'h1);
        hw_cycle(1'b0, 1'b0, 1'b0);
        hw_cycle(1'b0, 1'b1, 1'b0);
        hw_cycle(1'b1, 1'b0, 1'b0);
        hw_cycle(1'b0, 1'b0, 1'b1);
        test_done();
    end
endmodule
